// ==== hw/sync_byte_fifo_consts.svh ====
// timing counts and reset values shared by both ends of the byte fifo port
`ifndef SYNC_BYTE_FIFO_CONSTS_SVH
`define SYNC_BYTE_FIFO_CONSTS_SVH

// =============================================================
// clock figures
`define SYS_CLK_KHZ        50000
`define PORT_CLK_NOM_KHZ   60000
// half period of the port clock in system cycles
`define PORT_HALF_DEFAULT  6
// least half period: sync latency of both ends must fit in one half period
`define PORT_HALF_MIN      6

// =============================================================
// widths and reset values
`define DATA_W             8
`define FLAG_RESET         1'b1
`define STROBE_IDLE        1'b1
`define BUS_IDLE           8'hFF

`endif

// ==== hw/sync_byte_fifo_pkg.sv ====
// types shared by both ends of the byte fifo port
package sync_byte_fifo_pkg;

  // =============================================================
  // far end sequencer
  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_TURN,
    HOST_READ,
    HOST_WRITE
  } host_state_t;

  typedef logic [7:0] byte_t;

endpackage

// ==== hw/sync_byte_fifo_if.sv ====
// link between the bridge end and the external logic end
`timescale 1ns/1ns
interface sync_byte_fifo_if;
  import sync_byte_fifo_pkg::*;

  logic  port_clock_out;
  logic  rx_available_n;
  logic  tx_space_n;
  logic  power_enable_indicator_n;
  logic  read_strobe_n;
  logic  write_strobe_n;
  logic  output_enable_n;
  logic  send_now_wakeup_n;
  byte_t dev_data_out;
  logic  dev_data_oe_n;
  byte_t host_data_out;
  logic  host_data_oe_n;
  byte_t fifo_data_bus;

  // =============================================================
  // resolved bus level, pulled high when nobody drives
  assign fifo_data_bus = !dev_data_oe_n  ? dev_data_out  :
                         !host_data_oe_n ? host_data_out : 8'hFF;

  modport device (
    output port_clock_out,
    output rx_available_n,
    output tx_space_n,
    output power_enable_indicator_n,
    output dev_data_out,
    output dev_data_oe_n,
    input  read_strobe_n,
    input  write_strobe_n,
    input  output_enable_n,
    input  send_now_wakeup_n,
    input  fifo_data_bus
  );

  modport host (
    input  port_clock_out,
    input  rx_available_n,
    input  tx_space_n,
    input  power_enable_indicator_n,
    output host_data_out,
    output host_data_oe_n,
    output read_strobe_n,
    output write_strobe_n,
    output output_enable_n,
    output send_now_wakeup_n,
    input  fifo_data_bus
  );
endinterface

// ==== hw/sync_byte_fifo_dev.sv ====
// bridge end of the synchronous byte fifo port
`timescale 1ns/1ns
`include "sync_byte_fifo_consts.svh"

module sync_byte_fifo_dev
  import sync_byte_fifo_pkg::*;
#(
  parameter int HALF_PERIOD = `PORT_HALF_DEFAULT
)(
  // clock and reset
  input  wire logic          I_CLK_SYS,
  input  wire logic          I_RSTN,
  // link to the external logic
  sync_byte_fifo_if.device   link,
  // receive stream from the usb side
  input  wire logic [7:0]    i_RX_DATA,
  input  wire logic          i_RX_VALID,
  output logic               o_RX_READY,
  // transmit stream to the usb side
  output logic [7:0]         o_TX_DATA,
  output logic               o_TX_VALID,
  input  wire logic          i_TX_READY,
  // power state and usb side events
  input  wire logic          i_SUSPEND,
  input  wire logic          i_REMOTE_WAKE_EN,
  output logic               o_RESUME_REQ,
  output logic               o_SEND_NOW
);

  localparam int CW = $clog2(HALF_PERIOD + 1);

  // =============================================================
  // parameter check
  if (HALF_PERIOD < `PORT_HALF_MIN)
  begin : g_half_check
    $error("HALF_PERIOD too short for the sync latency of both ends");
  end

  // =============================================================
  // port clock divider
  logic [CW-1:0] div_cnt_q;
  logic          port_clk_q;
  logic          div_end;
  logic          rise;

  assign div_end = (div_cnt_q == CW'(HALF_PERIOD - 1));
  assign rise    = div_end && !port_clk_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      div_cnt_q  <= '0;
      port_clk_q <= 1'b0;
    end
    else if (div_end)
    begin
      div_cnt_q  <= '0;
      port_clk_q <= !port_clk_q;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  assign link.port_clock_out = port_clk_q;

  // =============================================================
  // input synchronisers
  logic [3:0] ctl_s1_q;
  logic [3:0] ctl_s2_q;
  byte_t      bus_s1_q;
  byte_t      bus_s2_q;
  logic       rd_n_s;
  logic       wr_n_s;
  logic       oe_n_s;
  logic       send_now_wakeup_n_n_s;

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      ctl_s1_q <= 4'hF;
      ctl_s2_q <= 4'hF;
      bus_s1_q <= `BUS_IDLE;
      bus_s2_q <= `BUS_IDLE;
    end
    else
    begin
      ctl_s1_q <= {link.read_strobe_n, link.write_strobe_n,
                   link.output_enable_n, link.send_now_wakeup_n};
      ctl_s2_q <= ctl_s1_q;
      bus_s1_q <= link.fifo_data_bus;
      bus_s2_q <= bus_s1_q;
    end
  end

  assign rd_n_s   = ctl_s2_q[3];
  assign wr_n_s   = ctl_s2_q[2];
  assign oe_n_s   = ctl_s2_q[1];
  assign send_now_wakeup_n_n_s = ctl_s2_q[0];

  // =============================================================
  // receive buffer towards the external logic
  byte_t rx_q;
  logic  rx_v_q;
  logic  rx_avail_n_q;
  logic  rx_take;

  assign rx_take    = rise && !rx_avail_n_q && !rd_n_s;
  assign o_RX_READY = rise && (!rx_v_q || rx_take);

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      rx_q         <= '0;
      rx_v_q       <= 1'b0;
      rx_avail_n_q <= `FLAG_RESET;
    end
    else if (rise)
    begin
      if (o_RX_READY)
      begin
        rx_v_q       <= i_RX_VALID;
        rx_avail_n_q <= !i_RX_VALID;
        if (i_RX_VALID)
        begin
          rx_q <= i_RX_DATA;
        end
      end
      else
      begin
        rx_avail_n_q <= !rx_v_q;
      end
    end
  end

  assign link.rx_available_n = rx_avail_n_q;
  assign link.dev_data_out   = rx_q;
  assign link.dev_data_oe_n  = oe_n_s;

  // =============================================================
  // transmit buffer from the external logic
  byte_t tx_q;
  logic  tx_v_q;
  logic  tx_space_n_q;
  logic  tx_cap;

  assign tx_cap = rise && !tx_space_n_q && !wr_n_s;

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      tx_q   <= '0;
      tx_v_q <= 1'b0;
    end
    else if (tx_cap)
    begin
      tx_q   <= bus_s2_q;
      tx_v_q <= 1'b1;
    end
    else if (tx_v_q && i_TX_READY)
    begin
      tx_v_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      tx_space_n_q <= `FLAG_RESET;
    end
    else if (rise)
    begin
      tx_space_n_q <= tx_cap || (tx_v_q && !i_TX_READY);
    end
  end

  assign link.tx_space_n = tx_space_n_q;
  assign o_TX_DATA       = tx_q;
  assign o_TX_VALID      = tx_v_q;

  // =============================================================
  // power indicator and send now / wakeup strobe
  logic pwr_n_q;
  logic send_now_wakeup_n_prev_q;
  logic send_now_wakeup_n_fall;
  logic resume_q;
  logic send_q;

  assign send_now_wakeup_n_fall = send_now_wakeup_n_prev_q && !send_now_wakeup_n_n_s;

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      pwr_n_q     <= 1'b1;
      send_now_wakeup_n_prev_q <= 1'b1;
      resume_q    <= 1'b0;
      send_q      <= 1'b0;
    end
    else
    begin
      pwr_n_q     <= i_SUSPEND;
      send_now_wakeup_n_prev_q <= send_now_wakeup_n_n_s;
      resume_q    <= send_now_wakeup_n_fall && pwr_n_q && i_REMOTE_WAKE_EN;
      send_q      <= send_now_wakeup_n_fall && !pwr_n_q;
    end
  end

  assign link.power_enable_indicator_n = pwr_n_q;
  assign o_RESUME_REQ                  = resume_q;
  assign o_SEND_NOW                    = send_q;

endmodule

// ==== hw/sync_byte_fifo_host.sv ====
// external logic end of the synchronous byte fifo port
`timescale 1ns/1ns
`include "sync_byte_fifo_consts.svh"

module sync_byte_fifo_host
  import sync_byte_fifo_pkg::*;
(
  // clock and reset
  input  wire logic          I_CLK_SYS,
  input  wire logic          I_RSTN,
  // link to the bridge
  sync_byte_fifo_if.host     link,
  // received bytes
  input  wire logic          i_RX_ENABLE,
  output logic [7:0]         o_RX_DATA,
  output logic               o_RX_VALID,
  // bytes to send
  input  wire logic [7:0]    i_TX_DATA,
  input  wire logic          i_TX_VALID,
  output logic               o_TX_READY,
  // send now request and power state
  input  wire logic          i_SEND_NOW,
  output logic               o_SUSPENDED
);

  // =============================================================
  // input synchronisers
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  byte_t      bus_s1_q;
  byte_t      bus_s2_q;
  logic       clk_prev_q;
  logic       fall;
  logic       rx_ok;
  logic       tx_ok;

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      pin_s1_q   <= 4'hE;
      pin_s2_q   <= 4'hE;
      bus_s1_q   <= `BUS_IDLE;
      bus_s2_q   <= `BUS_IDLE;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      pin_s1_q   <= {link.rx_available_n, link.tx_space_n,
                     link.power_enable_indicator_n, link.port_clock_out};
      pin_s2_q   <= pin_s1_q;
      bus_s1_q   <= link.fifo_data_bus;
      bus_s2_q   <= bus_s1_q;
      clk_prev_q <= pin_s2_q[0];
    end
  end

  // act mid period, when flags and data set at the last rise are settled
  assign fall  = clk_prev_q && !pin_s2_q[0];
  assign rx_ok = !pin_s2_q[3];
  assign tx_ok = !pin_s2_q[2];

  // =============================================================
  // strobe sequencer
  host_state_t state_q;
  logic        rd_n_q;
  logic        wr_n_q;
  logic        oe_n_q;
  logic        bus_oe_n_q;
  byte_t       out_q;
  logic        rx_take;

  assign rx_take    = fall && rx_ok &&
                      ((state_q == HOST_TURN) || (state_q == HOST_READ && i_RX_ENABLE));
  assign o_TX_READY = fall && tx_ok && i_TX_VALID &&
                      ((state_q == HOST_WRITE) ||
                       (state_q == HOST_IDLE && !(rx_ok && i_RX_ENABLE)));

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      state_q    <= HOST_IDLE;
      rd_n_q     <= `STROBE_IDLE;
      wr_n_q     <= `STROBE_IDLE;
      oe_n_q     <= `STROBE_IDLE;
      bus_oe_n_q <= 1'b1;
      out_q      <= '0;
    end
    else if (fall)
    begin
      unique case (state_q)
        HOST_IDLE:
        begin
          if (rx_ok && i_RX_ENABLE)
          begin
            oe_n_q  <= 1'b0;
            state_q <= HOST_TURN;
          end
          else if (o_TX_READY)
          begin
            wr_n_q     <= 1'b0;
            bus_oe_n_q <= 1'b0;
            out_q      <= i_TX_DATA;
            state_q    <= HOST_WRITE;
          end
        end
        HOST_TURN:
        begin
          if (rx_ok)
          begin
            rd_n_q  <= 1'b0;
            state_q <= HOST_READ;
          end
          else
          begin
            oe_n_q  <= 1'b1;
            state_q <= HOST_IDLE;
          end
        end
        HOST_READ:
        begin
          if (!rx_take)
          begin
            rd_n_q  <= 1'b1;
            oe_n_q  <= 1'b1;
            state_q <= HOST_IDLE;
          end
        end
        HOST_WRITE:
        begin
          if (o_TX_READY)
          begin
            out_q <= i_TX_DATA;
          end
          else
          begin
            wr_n_q     <= 1'b1;
            bus_oe_n_q <= 1'b1;
            state_q    <= HOST_IDLE;
          end
        end
      endcase
    end
  end

  assign link.read_strobe_n   = rd_n_q;
  assign link.write_strobe_n  = wr_n_q;
  assign link.output_enable_n = oe_n_q;
  assign link.host_data_out   = out_q;
  assign link.host_data_oe_n  = bus_oe_n_q || !oe_n_q;

  // =============================================================
  // received byte capture
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      o_RX_DATA  <= '0;
      o_RX_VALID <= 1'b0;
    end
    else
    begin
      o_RX_VALID <= rx_take;
      if (rx_take)
      begin
        o_RX_DATA <= bus_s2_q;
      end
    end
  end

  // =============================================================
  // send now / wakeup strobe, one port period low
  logic pend_q;
  logic send_now_wakeup_n_n_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      pend_q   <= 1'b0;
      send_now_wakeup_n_n_q <= 1'b1;
    end
    else
    begin
      pend_q <= i_SEND_NOW || (pend_q && !(fall && send_now_wakeup_n_n_q));
      if (fall)
      begin
        send_now_wakeup_n_n_q <= !(send_now_wakeup_n_n_q && pend_q);
      end
    end
  end

  assign link.send_now_wakeup_n = send_now_wakeup_n_n_q;
  assign o_SUSPENDED            = pin_s2_q[1];

endmodule

// ==== verif/sync_byte_fifo_port_sva.sv ====
// link assertions for the synchronous byte fifo port
`timescale 1ns/1ns
module sync_byte_fifo_port_sva
  import sync_byte_fifo_pkg::*;
#(
  parameter int HALF_PERIOD = 6
)(
  // clock and reset
  input wire logic  I_CLK_SYS,
  input wire logic  I_RSTN,
  // link signals
  input wire logic  port_clock_out,
  input wire logic  rx_available_n,
  input wire logic  tx_space_n,
  input wire logic  read_strobe_n,
  input wire logic  write_strobe_n,
  input wire logic  output_enable_n,
  input wire logic  send_now_wakeup_n,
  input wire byte_t dev_data_out,
  input wire logic  dev_data_oe_n,
  input wire logic  host_data_oe_n
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);

  // =============================================================
  // helper counters
  logic clk_prev_q;
  logic seen_q;
  int   half_cnt_q;
  int   oe_low_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      clk_prev_q <= 1'h0;
      seen_q     <= 1'h0;
      half_cnt_q <= 0;
    end
    else
    begin
      clk_prev_q <= port_clock_out;
      seen_q     <= seen_q | (port_clock_out != clk_prev_q);
      half_cnt_q <= (port_clock_out != clk_prev_q) ? 1 : half_cnt_q + 1;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
      oe_low_q <= 0;
    else
      oe_low_q <= output_enable_n ? 0 : oe_low_q + 1;
  end

  // =============================================================
  // assertions
  AST_CLK_HALF: assert property ((port_clock_out != clk_prev_q) && seen_q
    |-> half_cnt_q == HALF_PERIOD) else $error("port clock half period wrong");
  AST_RX_FLAG_AT_RISE: assert property ($changed(rx_available_n)
    |-> $rose(port_clock_out)) else $error("receive flag moved off a rise");
  AST_TX_FLAG_AT_RISE: assert property ($changed(tx_space_n)
    |-> $rose(port_clock_out)) else $error("transmit flag moved off a rise");
  AST_RX_DATA_AT_RISE: assert property ($changed(dev_data_out)
    |-> $rose(port_clock_out)) else $error("receive byte moved off a rise");
  AST_RX_FLAG_CLEAR: assert property ($rose(rx_available_n)
    |-> !read_strobe_n) else $error("receive flag rose without a read");
  AST_TX_FLAG_SET: assert property ($rose(tx_space_n)
    |-> !write_strobe_n) else $error("transmit flag rose without a write");
  AST_DEV_OE_FOLLOW: assert property ($fell(output_enable_n)
    |-> ##[1:4] !dev_data_oe_n) else $error("device did not drive the bus");
  AST_DEV_OE_RELEASE: assert property ($rose(output_enable_n)
    |-> ##[1:4] dev_data_oe_n) else $error("device kept driving the bus");
  AST_NO_CONTENTION: assert property (!(!dev_data_oe_n && !host_data_oe_n))
    else $error("bus driven from both ends");
  AST_OE_LEAD: assert property ($fell(read_strobe_n)
    |-> oe_low_q >= 2 * HALF_PERIOD) else $error("read before bus turn-around");
  AST_RD_NEEDS_FLAG: assert property ($fell(read_strobe_n)
    |-> !rx_available_n) else $error("read while receive flag high");
  AST_WR_NEEDS_FLAG: assert property ($fell(write_strobe_n)
    |-> !tx_space_n) else $error("write while transmit flag high");

  COV_READ: cover property ($fell(read_strobe_n));
  COV_WRITE: cover property ($rose(tx_space_n));
  COV_SEND_NOW: cover property ($fell(send_now_wakeup_n));
endmodule

// ==== verif/sync_byte_fifo_port_tb.sv ====
// self-checking bench joining both ends of the byte fifo port
`timescale 1ns/1ns
module sync_byte_fifo_port_tb;
  import sync_byte_fifo_pkg::*;
  localparam int HALF = 6;

  logic  clk = 1'h0;
  logic  rstn = 1'h0;
  byte_t usb_rx_data = 8'h00;
  logic  usb_rx_valid = 1'h0;
  logic  usb_rx_ready;
  byte_t usb_tx_data;
  logic  usb_tx_valid;
  logic  usb_tx_ready = 1'h1;
  logic  suspend = 1'h0;
  logic  wake_en = 1'h0;
  logic  resume_req;
  logic  send_now;
  logic  rx_en = 1'h0;
  byte_t app_rx_data;
  logic  app_rx_valid;
  byte_t app_tx_data = 8'h00;
  logic  app_tx_valid = 1'h0;
  logic  app_tx_ready;
  logic  app_send_now = 1'h0;
  logic  app_suspended;
  int    error_cnt = 0;
  int    checks = 0;
  int    cycles = 0;
  int    resume_cnt = 0;
  int    flush_cnt = 0;
  byte_t got_q[$];
  byte_t sent_q[$];
  byte_t pat[4] = '{8'h00, 8'hA5, 8'h5A, 8'hFF};

  sync_byte_fifo_if link ();
  sync_byte_fifo_dev #(.HALF_PERIOD(HALF)) u_sync_byte_fifo_dev (
    .I_CLK_SYS(clk), .I_RSTN(rstn), .link(link),
    .i_RX_DATA(usb_rx_data), .i_RX_VALID(usb_rx_valid), .o_RX_READY(usb_rx_ready),
    .o_TX_DATA(usb_tx_data), .o_TX_VALID(usb_tx_valid), .i_TX_READY(usb_tx_ready),
    .i_SUSPEND(suspend), .i_REMOTE_WAKE_EN(wake_en),
    .o_RESUME_REQ(resume_req), .o_SEND_NOW(send_now));
  sync_byte_fifo_host u_sync_byte_fifo_host (
    .I_CLK_SYS(clk), .I_RSTN(rstn), .link(link),
    .i_RX_ENABLE(rx_en), .o_RX_DATA(app_rx_data), .o_RX_VALID(app_rx_valid),
    .i_TX_DATA(app_tx_data), .i_TX_VALID(app_tx_valid), .o_TX_READY(app_tx_ready),
    .i_SEND_NOW(app_send_now), .o_SUSPENDED(app_suspended));
  sync_byte_fifo_port_sva #(.HALF_PERIOD(HALF)) u_sync_byte_fifo_port_sva (
    .I_CLK_SYS(clk), .I_RSTN(rstn), .port_clock_out(link.port_clock_out),
    .rx_available_n(link.rx_available_n), .tx_space_n(link.tx_space_n),
    .read_strobe_n(link.read_strobe_n), .write_strobe_n(link.write_strobe_n),
    .output_enable_n(link.output_enable_n), .send_now_wakeup_n(link.send_now_wakeup_n),
    .dev_data_out(link.dev_data_out), .dev_data_oe_n(link.dev_data_oe_n),
    .host_data_oe_n(link.host_data_oe_n));

  always #10 clk = ~clk;

  // =============================================================
  // monitors and timeout
  always @(posedge clk)
  begin
    cycles++;
    if (app_rx_valid === 1'h1)
      got_q.push_back(app_rx_data);
    if (usb_tx_valid === 1'h1 && usb_tx_ready === 1'h1)
      sent_q.push_back(usb_tx_data);
    if (resume_req === 1'h1)
      resume_cnt++;
    if (send_now === 1'h1)
      flush_cnt++;
    if (cycles == 6000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  // =============================================================
  // tasks
  task automatic cmp_byte(input byte_t got, input byte_t exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic usb_push(input byte_t b);
    usb_rx_data = b;
    usb_rx_valid = 1'h1;
    @(posedge clk);
    while (usb_rx_ready !== 1'h1) @(posedge clk);
    #1;
  endtask

  task automatic app_send(input byte_t b);
    app_tx_data = b;
    app_tx_valid = 1'h1;
    @(posedge clk);
    while (app_tx_ready !== 1'h1) @(posedge clk);
    #1;
  endtask

  task automatic end_test(input string name);
    $display("test %0s done, mismatches so far %0d", name, error_cnt);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // =============================================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'h1;
    rx_en = 1'h1;
    foreach (pat[i]) usb_push(pat[i]);
    usb_rx_valid = 1'h0;
    while (got_q.size() < 4) @(posedge clk);
    foreach (pat[i]) cmp_byte(got_q[i], pat[i]);
    end_test("receive stream");
    #1;
    rx_en = 1'h0;
    usb_push(8'h3C);
    usb_rx_valid = 1'h0;
    repeat (40) @(posedge clk);
    cmp_bit(link.rx_available_n, 1'h0);
    cmp_byte(byte_t'(got_q.size()), 8'h04);
    #1;
    rx_en = 1'h1;
    while (got_q.size() < 5) @(posedge clk);
    cmp_byte(got_q[4], 8'h3C);
    repeat (40) @(posedge clk);
    cmp_bit(link.rx_available_n, 1'h1);
    cmp_bit(link.dev_data_oe_n, 1'h1);
    cmp_byte(link.fifo_data_bus, 8'hFF);
    end_test("held byte");
    #1;
    usb_tx_ready = 1'h0;
    app_send(8'hC3);
    app_tx_valid = 1'h0;
    repeat (40) @(posedge clk);
    cmp_bit(link.tx_space_n, 1'h1);
    cmp_bit(usb_tx_valid, 1'h1);
    cmp_byte(usb_tx_data, 8'hC3);
    #1;
    usb_tx_ready = 1'h1;
    foreach (pat[i]) app_send(pat[i]);
    app_tx_valid = 1'h0;
    while (sent_q.size() < 5) @(posedge clk);
    cmp_byte(sent_q[0], 8'hC3);
    foreach (pat[i]) cmp_byte(sent_q[i + 1], pat[i]);
    end_test("transmit stream");
    for (int k = 0; k < 3; k++)
    begin
      #1;
      suspend = (k != 0);
      wake_en = (k == 1);
      while (app_suspended !== suspend) @(posedge clk);
      @(posedge clk);
      #1;
      resume_cnt = 0;
      flush_cnt = 0;
      app_send_now = 1'h1;
      @(posedge clk);
      #1;
      app_send_now = 1'h0;
      repeat (60) @(posedge clk);
      cmp_byte(byte_t'(flush_cnt), (k == 0) ? 8'h01 : 8'h00);
      cmp_byte(byte_t'(resume_cnt), (k == 1) ? 8'h01 : 8'h00);
    end
    end_test("send now and wakeup");
    wrap_up();
  end
endmodule
